// ==== core/srpr_map.svh ====
// offsets, field positions and reset values for the serial load block
`ifndef SRPR_MAP_SVH
`define SRPR_MAP_SVH
`define SRPR_WORD_W 24
`define SRPR_SEL_MSB 1
`define SRPR_SEL_LSB 0
`define SRPR_SEL_FREQ 2'h0
`define SRPR_SEL_REFDIV 2'h1
`define SRPR_SEL_CTRLW 2'h2
`define SRPR_SEL_CTRLW_IDX 2
`define SRPR_CNT_MSB 15
`define SRPR_CNT_LSB 12
`define SRPR_MULT_MSB 13
`define SRPR_MULT_LSB 3
`define SRPR_LOADCTL_BIT 23
`define SRPR_ADDR_W 8
`define SRPR_A_CTRL 8'h00
`define SRPR_A_STATUS 8'h04
`define SRPR_A_WORD0 8'h10
`define SRPR_A_WORD1 8'h14
`define SRPR_A_WORD2 8'h18
`define SRPR_A_WORD3 8'h1C
`define SRPR_A_MULT 8'h20
`define SRPR_A_SYNCCNT 8'h24
`define SRPR_A_LOADCNT 8'h28
`define SRPR_CTRL_RST 2'h3
`define SRPR_CTRL_SYNC_BIT 0
`define SRPR_CTRL_ALIGN_BIT 1
`endif

// ==== core/srpr_pkg.sv ====
// types for the serial load and phase resync block
package srpr_pkg;
  typedef enum logic [1:0] {
    ALIGN_IDLE,
    ALIGN_WAIT_FIRST,
    ALIGN_WAIT_SECOND
  } srpr_align_type;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic [23:0] shreg;
  } srpr_link_type;

  typedef struct packed {
    logic le_s1;
    logic le_s2;
    logic le_d;
    logic [3:0][23:0] words;
    logic [10:0] mult;
    logic [14:0] timer;
    logic sync_q;
    logic align_q;
    srpr_align_type align_st;
    logic [15:0] sync_cnt;
    logic [15:0] load_cnt;
    logic [1:0] ctrl;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic sync_pin;
    logic align_pin;
    logic enabled_pin;
  } srpr_core_type;
endpackage

// ==== core/srpr_top.sv ====
// serial load port, resync timer and bus registers
//
// Overview of operation
// - while enabled, a sync pulse comes every count times multiplier cycles
// - resync count is control word bits 15..12; values 1..15 enable
// - resync count zero disables sync pulses and any phase realignment
// - reference-divider word with bit 23 set stores bits 13..3 as multiplier
// - second sync pulse after a frequency load realigns output phase
// - one data bit shifts in on every rising serial clock edge
// - rising latch strobe moves the shifted word to the selected register
// - resync timer counts phase-detector reference cycles
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "srpr_map.svh"

module srpr_top
  import srpr_pkg::*;
#(
  parameter int SYNC_CNT_W = 16
) (
  // phase-detector clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // serial load pins
  input wire logic SCLK,
  input wire logic SDATA,
  input wire logic LATCH_STROBE,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  // resync outputs
  output logic SYNC_PULSE,
  output logic PHASE_ALIGN,
  output logic RESYNC_ENABLED
);

  srpr_link_type lk;
  srpr_link_type ln;
  srpr_core_type r;
  srpr_core_type n;
  logic commit;
  logic commit_frq;
  logic [1:0] sel;
  logic [3:0] rcount;
  logic [14:0] period;

  function automatic logic [14:0] period_of(
    input logic [3:0] c,
    input logic [10:0] m
  );
    logic [14:0] p;
    p = {11'h000, c} * {4'h0, m};
    return p;
  endfunction

  function automatic logic [31:0] word_rd(input logic [23:0] w);
    logic [31:0] d;
    d = {8'h00, w};
    return d;
  endfunction

  // serial clock domain
  always_comb begin
    ln = lk;
    ln.rst_s1 = SYS_RST;
    ln.rst_s2 = lk.rst_s1;
    ln.shreg = {lk.shreg[`SRPR_WORD_W-2:0], SDATA};
    if (lk.rst_s2) begin
      ln.shreg = '0;
    end
  end

  always_ff @(posedge SCLK) begin
    lk <= ln;
  end

  // word still static: serial clock idles while strobe is high
  assign sel = lk.shreg[`SRPR_SEL_MSB:`SRPR_SEL_LSB];
  assign commit = r.le_s2 & ~r.le_d;
  assign commit_frq = commit & (sel == `SRPR_SEL_FREQ);
  assign rcount = r.words[`SRPR_SEL_CTRLW_IDX][`SRPR_CNT_MSB:`SRPR_CNT_LSB];
  assign period = period_of(rcount, r.mult);

  // reference clock domain
  always_comb begin
    n = r;
    n.le_s1 = LATCH_STROBE;
    n.le_s2 = r.le_s1;
    n.le_d = r.le_s2;
    n.sync_q = 1'b0;
    n.align_q = 1'b0;
    if (commit) begin
      n.words[sel] = lk.shreg;
      n.load_cnt = r.load_cnt + 16'h0001;
      if (sel == `SRPR_SEL_REFDIV && lk.shreg[`SRPR_LOADCTL_BIT]) begin
        n.mult = lk.shreg[`SRPR_MULT_MSB:`SRPR_MULT_LSB];
      end
    end
    if (rcount == 4'h0) begin
      n.timer = 15'h0000;
    end else if (period <= 15'h0001 || r.timer >= period - 15'h0001) begin
      n.timer = 15'h0000;
      n.sync_q = 1'b1;
    end else begin
      n.timer = r.timer + 15'h0001;
    end
    if (n.sync_q) begin
      n.sync_cnt = r.sync_cnt + 16'h0001;
    end
    if (commit_frq) begin
      n.align_st = ALIGN_WAIT_FIRST;
    end else begin
      case (r.align_st)
        ALIGN_IDLE: begin
          n.align_st = ALIGN_IDLE;
        end
        ALIGN_WAIT_FIRST: begin
          if (rcount == 4'h0) begin
            n.align_st = ALIGN_IDLE;
          end else if (n.sync_q) begin
            n.align_st = ALIGN_WAIT_SECOND;
          end
        end
        ALIGN_WAIT_SECOND: begin
          if (rcount == 4'h0) begin
            n.align_st = ALIGN_IDLE;
          end else if (n.sync_q) begin
            n.align_st = ALIGN_IDLE;
            n.align_q = 1'b1;
          end
        end
        default: begin
          n.align_st = ALIGN_IDLE;
        end
      endcase
    end
    // bus data phase write
    if (r.ap_valid && r.ap_write && r.ap_addr == `SRPR_A_CTRL) begin
      n.ctrl = HWDATA[1:0];
    end
    // bus address phase
    n.ap_valid = HSEL & HTRANS[1] & HREADY;
    n.ap_write = HWRITE;
    n.ap_addr = HADDR[`SRPR_ADDR_W-1:0];
    n.hready = 1'b1;
    n.hresp = 1'b0;
    n.hrdata = 32'h00000000;
    if (n.ap_valid && !HWRITE) begin
      case (HADDR[`SRPR_ADDR_W-1:0])
        `SRPR_A_CTRL: begin
          n.hrdata = {30'h00000000, n.ctrl};
        end
        `SRPR_A_STATUS: begin
          n.hrdata = {30'h00000000, n.align_st != ALIGN_IDLE,
                      n.words[`SRPR_SEL_CTRLW_IDX][`SRPR_CNT_MSB:
                      `SRPR_CNT_LSB] != 4'h0};
        end
        `SRPR_A_WORD0: begin
          n.hrdata = word_rd(n.words[0]);
        end
        `SRPR_A_WORD1: begin
          n.hrdata = word_rd(n.words[1]);
        end
        `SRPR_A_WORD2: begin
          n.hrdata = word_rd(n.words[2]);
        end
        `SRPR_A_WORD3: begin
          n.hrdata = word_rd(n.words[3]);
        end
        `SRPR_A_MULT: begin
          n.hrdata = {21'h000000, n.mult};
        end
        `SRPR_A_SYNCCNT: begin
          n.hrdata = {16'h0000, n.sync_cnt};
        end
        `SRPR_A_LOADCNT: begin
          n.hrdata = {16'h0000, n.load_cnt};
        end
        default: begin
          n.hrdata = 32'h00000000;
        end
      endcase
    end
    // output pins: sync and align gated by control bits, enabled not gated
    n.sync_pin = n.sync_q & n.ctrl[`SRPR_CTRL_SYNC_BIT];
    n.align_pin = n.align_q & n.ctrl[`SRPR_CTRL_ALIGN_BIT];
    n.enabled_pin =
      n.words[`SRPR_SEL_CTRLW_IDX][`SRPR_CNT_MSB:`SRPR_CNT_LSB] != 4'h0;
    if (SYS_RST) begin
      n = '0;
      n.ctrl = `SRPR_CTRL_RST;
      // strobe idles high: no false commit after reset
      n.le_s1 = 1'b1;
      n.le_s2 = 1'b1;
      n.le_d = 1'b1;
      n.hready = 1'b1;
      n.align_st = ALIGN_IDLE;
    end
  end

  always_ff @(posedge REF_CLK) begin
    r <= n;
  end

  assign HREADYOUT = r.hready;
  assign HRDATA = r.hrdata;
  assign HRESP = r.hresp;
  assign SYNC_PULSE = r.sync_pin;
  assign PHASE_ALIGN = r.align_pin;
  assign RESYNC_ENABLED = r.enabled_pin;

  // checking helpers
  logic [15:0] gap_cnt;
  logic gap_ok;
  logic [14:0] period_q;
  logic [1:0] since_frq;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      gap_cnt <= 16'h0000;
      gap_ok <= 1'b0;
      period_q <= 15'h0000;
      since_frq <= 2'h0;
    end else begin
      period_q <= period;
      gap_cnt <= r.sync_q ? 16'h0001 : gap_cnt + 16'h0001;
      if (period != period_q) begin
        gap_ok <= 1'b0;
      end else if (r.sync_q) begin
        gap_ok <= 1'b1;
      end
      if (commit_frq) begin
        since_frq <= 2'h0;
      end else if (n.sync_q && since_frq != 2'h3) begin
        since_frq <= since_frq + 2'h1;
      end
    end
  end

  a_sync_spacing: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    r.sync_q && gap_ok && period == period_q && period > 15'h0001
    |-> gap_cnt == {1'b0, period})
    else $error("sync pulse spacing differs from period");

  a_count_field: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    commit && sel == `SRPR_SEL_CTRLW
    && lk.shreg[`SRPR_CNT_MSB:`SRPR_CNT_LSB] != 4'h0
    |-> ##2 RESYNC_ENABLED)
    else $error("nonzero count did not enable resync");

  a_disabled_quiet: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    rcount == 4'h0 && $past(rcount) == 4'h0
    |-> !r.sync_q && !r.align_q && r.timer == 15'h0000)
    else $error("activity while resync disabled");

  a_mult_load: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    commit && sel == `SRPR_SEL_REFDIV && lk.shreg[`SRPR_LOADCTL_BIT]
    |=> r.mult == $past(lk.shreg[`SRPR_MULT_MSB:`SRPR_MULT_LSB]))
    else $error("multiplier not loaded");

  a_mult_keep: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    commit && sel == `SRPR_SEL_REFDIV && !lk.shreg[`SRPR_LOADCTL_BIT]
    |=> $stable(r.mult))
    else $error("modulus load changed multiplier");

  a_align_second: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    r.align_q |-> r.sync_q && since_frq == 2'h2)
    else $error("realign not on second sync pulse");

  a_latch_commit: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    commit |=> r.words[$past(sel)] == $past(lk.shreg))
    else $error("word not committed on strobe edge");

  a_pulse_single: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    r.sync_q && period > 15'h0001 && $stable(period) |=> !r.sync_q)
    else $error("sync pulse longer than one cycle");

  a_timer_step: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    rcount != 4'h0 && !n.sync_q && $stable(period) && !SYS_RST
    |=> r.timer == $past(r.timer) + 15'h0001)
    else $error("timer did not advance by one");

  a_shift_in: assert property (
    @(posedge SCLK) disable iff (lk.rst_s2)
    ##2 !$past(lk.rst_s2, 2)
    |-> lk.shreg[1:0] == {$past(SDATA, 2), $past(SDATA)})
    else $error("serial bits not shifted in order");

  c_word_load: cover property (
    @(posedge REF_CLK) disable iff (SYS_RST) commit);
  c_sync_seen: cover property (
    @(posedge REF_CLK) disable iff (SYS_RST) r.sync_q);
  c_align_seen: cover property (
    @(posedge REF_CLK) disable iff (SYS_RST) r.align_q);
  c_mult_set: cover property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    commit && sel == `SRPR_SEL_REFDIV && lk.shreg[`SRPR_LOADCTL_BIT]);

endmodule

// ==== sim/srpr_host_model.sv ====
// serial master model driving the three-wire load port
`timescale 1ns/1ps

module srpr_host_model (
  // serial pins toward the device
  output logic sclk,
  output logic sdata,
  output logic latch_strobe
);
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    latch_strobe = 1'b1;
  end

  // clock pulses with data held low, used after reset
  // 60 ns serial period, below 20 MHz
  task automatic pulses(input int n);
    repeat (n) begin
      #30 sclk = 1'b1;
      #30 sclk = 1'b0;
    end
  endtask

  task automatic shift_word(input logic [23:0] w);
    latch_strobe = 1'b0;
    // msb first, data set while clock low
    for (int i = 23; i >= 0; i--) begin
      sdata = w[i];
      #30 sclk = 1'b1;
      #30 sclk = 1'b0;
    end
    sdata = ~w[0];
  endtask

  task automatic latch();
    // strobe high after last bit, then quiet
    #30 latch_strobe = 1'b1;
    #100;
  endtask
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the serial load and resync block
`timescale 1ns/1ps
`include "srpr_map.svh"

module tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sclk, sdata, latch_strobe;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, sync_pulse, phase_align, resync_en;
  logic [31:0] hrdata;
  logic [31:0] seed = 32'h0000AEEE;
  int miscompares = 0;
  int samples_checked = 0;
  logic [31:0] exp_q[$];
  logic rd_dphase = 1'b0;

  always #5 ref_clk = ~ref_clk;

  srpr_top i_srpr_top (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
    .SCLK(sclk), .SDATA(sdata), .LATCH_STROBE(latch_strobe),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp),
    .SYNC_PULSE(sync_pulse), .PHASE_ALIGN(phase_align),
    .RESYNC_ENABLED(resync_en));

  srpr_host_model i_srpr_host_model (.sclk(sclk), .sdata(sdata),
    .latch_strobe(latch_strobe));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic report_and_stop();
    if (exp_q.size() != 0) begin
      miscompares++;
    end
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    samples_checked++;
    if (v !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, v, e);
    end
  endtask

  // read data phase: oldest note against bus result
  always @(posedge ref_clk) begin
    if (rd_dphase && hreadyout === 1'b1) begin
      if (exp_q.size() > 0) begin
        chk(hrdata, exp_q.pop_front());
      end else begin
        miscompares++;
        $display("[FAIL] %0t read data with no expectation", $time);
      end
    end
    rd_dphase <= hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
  end

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, r);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic send(input logic [23:0] w);
    i_srpr_host_model.shift_word(w);
    i_srpr_host_model.latch();
  endtask

  task automatic next_sync(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (sync_pulse !== 1'b1);
  endtask

  initial begin
    // tests need about 1700 cycles; allow 20000
    #200000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    int n;
    int idx;
    logic [10:0] m;
    logic [3:0] c;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // serial side leaves reset before the first word
    i_srpr_host_model.pulses(3);
    rd(`SRPR_A_CTRL, 32'h3);
    rd(`SRPR_A_STATUS, 32'h0);
    rd(`SRPR_A_MULT, 32'h0);
    rd(8'h30, 32'h0);
    chk({31'h0, resync_en}, 32'h0);
    seed = xs(seed);
    wr(`SRPR_A_CTRL, seed);
    rd(`SRPR_A_CTRL, {30'h0, seed[1:0]});
    wr(`SRPR_A_CTRL, 32'h3);
    $display("register access test done");
    seed = xs(seed);
    m = 11'(5 * (1 + seed[2:0]));
    send({1'b1, 9'h0, m, 3'h1});
    rd(`SRPR_A_WORD1, {8'h0, 1'b1, 9'h0, m, 3'h1});
    rd(`SRPR_A_MULT, {21'h0, m});
    // modulus 5 keeps the multiplier a whole multiple of it
    send({1'b0, 9'h0, 11'h005, 3'h1});
    rd(`SRPR_A_WORD1, {8'h0, 1'b0, 9'h0, 11'h005, 3'h1});
    rd(`SRPR_A_MULT, {21'h0, m});
    $display("multiplier load test done");
    for (int k = 0; k < 2; k++) begin
      c = k ? 4'hF : 4'h1;
      // model loop settles at once, any period is long enough
      send({8'h0, c, 12'h2});
      chk({31'h0, resync_en}, 32'h1);
      next_sync(n);
      next_sync(n);
      chk(32'(n), 32'(c * m));
    end
    $display("sync period test done");
    send({8'h0, 4'h3, 12'h2});
    i_srpr_host_model.shift_word(24'h000120);
    next_sync(n);
    i_srpr_host_model.latch();
    idx = 0;
    for (int k = 1; k <= 3; k++) begin
      next_sync(n);
      if (phase_align === 1'b1) begin
        idx = k;
      end
    end
    chk(32'(idx), 32'h2);
    $display("phase realign test done");
    send({8'h0, 4'h0, 12'h2});
    rd(`SRPR_A_STATUS, 32'h0);
    n = 0;
    repeat (300) begin
      @(posedge ref_clk);
      if (sync_pulse !== 1'b0) begin
        n++;
      end
    end
    chk(32'(n), 32'h0);
    $display("disable test done");
    repeat (4) @(posedge ref_clk);
    report_and_stop();
  end
endmodule
